// ===== rtl/cdp_pkg.sv
// Constants for the core extension datapath: register addresses, fields, resets.
// Assumes an 8-bit register space addressed by the instruction sequencer.
package cdp_pkg;
  localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
  localparam logic [7:0] ADDR_PTR2_LOW    = 8'h84;
  localparam logic [7:0] ADDR_PTR2_HIGH   = 8'h85;
  localparam logic [7:0] ADDR_ARITH_MODE  = 8'h86;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_ACC         = 8'he0;
  localparam logic [7:0] ADDR_B           = 8'hf0;
  localparam logic [7:0] ADDR_EXTENSION   = 8'hf1;
  localparam logic [7:0] ADDR_XRAM_PAGE   = 8'hf7;
  // Status word fields
  localparam int SW_CARRY = 7;
  localparam int SW_HALF  = 6;
  localparam int SW_USERA = 5;
  localparam int SW_BANKH = 4;
  localparam int SW_BANKL = 3;
  localparam int SW_OVF   = 2;
  localparam int SW_USERB = 1;
  localparam int SW_PAR   = 0;
  // Mode register fields
  localparam int MODE_DIV = 3;
  localparam int MODE_MUL = 2;
  localparam int MODE_PTR = 0;
  localparam logic [7:0] MODE_MASK = 8'h0d;
  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_PTR   = 16'h0000;
  // Internal RAM boundary
  localparam logic [7:0] UPPER_RAM_BASE = 8'h80;
  // Operand addressing modes
  localparam logic [1:0] AM_DIRECT   = 2'h0;
  localparam logic [1:0] AM_INDIRECT = 2'h1;
  localparam logic [1:0] AM_REGISTER = 2'h3;
endpackage : cdp_pkg

// ===== rtl/cdp_muldiv.sv
// Combinational multiply and divide unit, 8-bit and 16-bit operand modes.
// Assumes the caller registers results and ignores them on a zero divisor.
`timescale 1ns/1ps
module cdp_muldiv (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [7:0] ext,
  input  wire logic       wide_mul,
  input  wire logic       wide_div,
  output logic      [7:0] mul_a,
  output logic      [7:0] mul_b,
  output logic      [7:0] mul_ext,
  output logic            mul_ovf,
  output logic      [7:0] div_a,
  output logic      [7:0] div_b,
  output logic      [7:0] div_ext,
  output logic            div_zero
);
  logic [23:0] prod;
  logic [15:0] num;
  logic [15:0] quot;
  logic [15:0] rem;

  always_comb
  begin
    prod = {8'h00, (wide_mul ? ext : 8'h00), a} * {16'h0000, b};
    mul_a = prod[7:0];
    mul_b = prod[15:8];
    mul_ext = wide_mul ? prod[23:16] : ext;
    mul_ovf = |prod[23:8];
    num = {(wide_div ? ext : 8'h00), a};
    div_zero = (b == 8'h00);
    quot = div_zero ? 16'h0000 : num / {8'h00, b};
    rem = div_zero ? 16'h0000 : num % {8'h00, b};
    div_a = quot[7:0];
    div_b = rem[7:0];
    div_ext = wide_div ? quot[15:8] : ext;
  end
endmodule : cdp_muldiv

// ===== rtl/cdp_datapath.sv
// Core extension datapath: status word, accumulator, B, extension register,
// dual data pointers, multiply/divide and data memory address resolution.
// Assumes the sequencer drives one-cycle request strobes on ref_clk.
`timescale 1ns/1ps
module cdp_datapath (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata_q,
  output logic             sfr_hit_q,
  input  wire logic        acc_we,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        flag_we,
  input  wire logic        carry_in,
  input  wire logic        half_in,
  input  wire logic        ovf_in,
  input  wire logic        op_mul,
  input  wire logic        op_div,
  output logic             muldiv_done_q,
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_wdata,
  input  wire logic        ptr_inc,
  output logic      [15:0] data_pointer_q,
  input  wire logic        am_valid,
  input  wire logic [1:0]  am_mode,
  input  wire logic [7:0]  am_addr,
  output logic             iram_en_q,
  output logic             sfr_en_q,
  output logic             am_fault_q,
  output logic      [7:0]  iram_addr_q,
  input  wire logic        xm_valid,
  input  wire logic        xm_via_ptr,
  input  wire logic [7:0]  xm_reg_value,
  output logic             xram_en_q,
  output logic      [15:0] xram_addr_q,
  output logic      [7:0]  acc_q,
  output logic      [7:0]  b_q,
  output logic      [7:0]  status_word_q
);
  logic [7:0]  ext_q;
  logic [7:0]  mode_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [7:0]  page_q;
  logic [7:0]  acc_d;
  logic [7:0]  b_d;
  logic [7:0]  ext_d;
  logic        div_ok;
  logic        wr_acc;
  logic        wr_b;
  logic        wr_ext;
  logic        wr_sw;
  logic        wr_mode;
  logic        wr_page;
  logic [7:0]  mul_a;
  logic [7:0]  mul_b;
  logic [7:0]  mul_ext;
  logic        mul_ovf;
  logic [7:0]  div_a;
  logic [7:0]  div_b;
  logic [7:0]  div_ext;
  logic        div_zero;
  logic [7:0]  rd_data;
  logic        rd_hit;

  function automatic logic sfr_is(input logic [7:0] a, input logic [7:0] ref_a);
    sfr_is = (a == ref_a);
  endfunction : sfr_is

  assign wr_acc  = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_ACC);
  assign wr_b    = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_B);
  assign wr_ext  = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_EXTENSION);
  assign wr_sw   = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_STATUS_WORD);
  assign wr_mode = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_ARITH_MODE);
  assign wr_page = sfr_wr && sfr_is(sfr_addr, cdp_pkg::ADDR_XRAM_PAGE);
  assign div_ok  = op_div && !div_zero;

  cdp_muldiv cdp_muldiv_inst (
    .a        (acc_q),
    .b        (b_q),
    .ext      (ext_q),
    .wide_mul (mode_q[cdp_pkg::MODE_MUL]),
    .wide_div (mode_q[cdp_pkg::MODE_DIV]),
    .mul_a    (mul_a),
    .mul_b    (mul_b),
    .mul_ext  (mul_ext),
    .mul_ovf  (mul_ovf),
    .div_a    (div_a),
    .div_b    (div_b),
    .div_ext  (div_ext),
    .div_zero (div_zero)
  );

  // Next values; arithmetic results win over register writes
  always_comb
  begin
    acc_d = acc_q;
    b_d = b_q;
    ext_d = ext_q;
    if (op_mul)
    begin
      acc_d = mul_a;
      b_d = mul_b;
      ext_d = mul_ext;
    end
    else if (div_ok)
    begin
      acc_d = div_a;
      b_d = div_b;
      ext_d = div_ext;
    end
    else if (!op_div)
    begin
      if (acc_we)
        acc_d = acc_wdata;
      else if (wr_acc)
        acc_d = sfr_wdata;
      if (wr_b)
        b_d = sfr_wdata;
      if (wr_ext)
        ext_d = sfr_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_q <= cdp_pkg::RST_BYTE;
      b_q <= cdp_pkg::RST_BYTE;
      ext_q <= cdp_pkg::RST_BYTE;
    end
    else
    begin
      acc_q <= acc_d;
      b_q <= b_d;
      ext_q <= ext_d;
    end
  end

  // Status word; parity follows the next accumulator value
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      status_word_q <= cdp_pkg::RST_BYTE;
    else
    begin
      status_word_q[cdp_pkg::SW_PAR] <= ^acc_d;
      if (wr_sw)
      begin
        status_word_q[cdp_pkg::SW_USERA] <= sfr_wdata[cdp_pkg::SW_USERA];
        status_word_q[cdp_pkg::SW_USERB] <= sfr_wdata[cdp_pkg::SW_USERB];
        status_word_q[cdp_pkg::SW_BANKH] <= sfr_wdata[cdp_pkg::SW_BANKH];
        status_word_q[cdp_pkg::SW_BANKL] <= sfr_wdata[cdp_pkg::SW_BANKL];
      end
      if (op_mul || op_div)
      begin
        status_word_q[cdp_pkg::SW_CARRY] <= 1'b0;
        status_word_q[cdp_pkg::SW_OVF] <= op_mul ? mul_ovf : div_zero;
      end
      else if (flag_we)
      begin
        status_word_q[cdp_pkg::SW_CARRY] <= carry_in;
        status_word_q[cdp_pkg::SW_HALF] <= half_in;
        status_word_q[cdp_pkg::SW_OVF] <= ovf_in;
      end
      else if (wr_sw)
      begin
        status_word_q[cdp_pkg::SW_CARRY] <= sfr_wdata[cdp_pkg::SW_CARRY];
        status_word_q[cdp_pkg::SW_HALF] <= sfr_wdata[cdp_pkg::SW_HALF];
        status_word_q[cdp_pkg::SW_OVF] <= sfr_wdata[cdp_pkg::SW_OVF];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      muldiv_done_q <= 1'b0;
    else
      muldiv_done_q <= op_mul || op_div;
  end

  // Mode register; cleared by reset so arithmetic starts narrow
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mode_q <= cdp_pkg::RST_BYTE;
    else if (wr_mode)
      mode_q <= sfr_wdata & cdp_pkg::MODE_MASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      page_q <= cdp_pkg::RST_BYTE;
    else if (wr_page)
      page_q <= sfr_wdata;
  end

  // Data pointers: byte writes, word load and increment on the active one
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ptr0_q <= cdp_pkg::RST_PTR;
      ptr1_q <= cdp_pkg::RST_PTR;
    end
    else if (ptr_load || ptr_inc)
    begin
      if (mode_q[cdp_pkg::MODE_PTR])
        ptr1_q <= ptr_load ? ptr_wdata : ptr1_q + 16'h0001;
      else
        ptr0_q <= ptr_load ? ptr_wdata : ptr0_q + 16'h0001;
    end
    else if (sfr_wr)
    begin
      if (sfr_is(sfr_addr, cdp_pkg::ADDR_PTR_LOW))
        ptr0_q[7:0] <= sfr_wdata;
      if (sfr_is(sfr_addr, cdp_pkg::ADDR_PTR_HIGH))
        ptr0_q[15:8] <= sfr_wdata;
      if (sfr_is(sfr_addr, cdp_pkg::ADDR_PTR2_LOW))
        ptr1_q[7:0] <= sfr_wdata;
      if (sfr_is(sfr_addr, cdp_pkg::ADDR_PTR2_HIGH))
        ptr1_q[15:8] <= sfr_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      data_pointer_q <= cdp_pkg::RST_PTR;
    else if (mode_q[cdp_pkg::MODE_PTR])
      data_pointer_q <= ptr1_q;
    else
      data_pointer_q <= ptr0_q;
  end

  // Register space read decode
  always_comb
  begin
    rd_hit = 1'b1;
    case (sfr_addr)
      cdp_pkg::ADDR_ACC:         rd_data = acc_q;
      cdp_pkg::ADDR_B:           rd_data = b_q;
      cdp_pkg::ADDR_EXTENSION:   rd_data = ext_q;
      cdp_pkg::ADDR_STATUS_WORD: rd_data = status_word_q;
      cdp_pkg::ADDR_ARITH_MODE:  rd_data = mode_q;
      cdp_pkg::ADDR_XRAM_PAGE:   rd_data = page_q;
      cdp_pkg::ADDR_PTR_LOW:     rd_data = ptr0_q[7:0];
      cdp_pkg::ADDR_PTR_HIGH:    rd_data = ptr0_q[15:8];
      cdp_pkg::ADDR_PTR2_LOW:    rd_data = ptr1_q[7:0];
      cdp_pkg::ADDR_PTR2_HIGH:   rd_data = ptr1_q[15:8];
      default:
      begin
        rd_data = cdp_pkg::RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sfr_rdata_q <= cdp_pkg::RST_BYTE;
      sfr_hit_q <= 1'b0;
    end
    else if (sfr_rd)
    begin
      sfr_rdata_q <= rd_data;
      sfr_hit_q <= rd_hit;
    end
    else
      sfr_hit_q <= 1'b0;
  end

  // Internal data memory address resolution
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      iram_en_q <= 1'b0;
      sfr_en_q <= 1'b0;
      am_fault_q <= 1'b0;
      iram_addr_q <= cdp_pkg::RST_BYTE;
    end
    else
    begin
      iram_en_q <= 1'b0;
      sfr_en_q <= 1'b0;
      am_fault_q <= 1'b0;
      if (am_valid)
      begin
        case (am_mode)
          cdp_pkg::AM_REGISTER:
          begin
            iram_en_q <= 1'b1;
            iram_addr_q <= {3'h0, status_word_q[cdp_pkg::SW_BANKH:cdp_pkg::SW_BANKL],
                            am_addr[2:0]};
          end
          cdp_pkg::AM_INDIRECT:
          begin
            iram_en_q <= 1'b1;
            iram_addr_q <= am_addr;
          end
          cdp_pkg::AM_DIRECT:
          begin
            iram_addr_q <= am_addr;
            if (am_addr < cdp_pkg::UPPER_RAM_BASE)
              iram_en_q <= 1'b1;
            else
              sfr_en_q <= 1'b1;
          end
          default:
            am_fault_q <= 1'b1;
        endcase
      end
    end
  end

  // External RAM address: pointer or page plus register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xram_en_q <= 1'b0;
      xram_addr_q <= cdp_pkg::RST_PTR;
    end
    else
    begin
      xram_en_q <= xm_valid;
      if (xm_valid)
      begin
        if (xm_via_ptr)
          xram_addr_q <= mode_q[cdp_pkg::MODE_PTR] ? ptr1_q : ptr0_q;
        else
          xram_addr_q <= {page_q, xm_reg_value};
      end
    end
  end
endmodule : cdp_datapath

// ===== sim/cdp_datapath_monitor.sv
// Checker for the datapath: result, flag and address relations at the ports.
// Assumes it is bound to cdp_datapath and reaches its ports by name.
`timescale 1ns/1ps
module cdp_datapath_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       op_mul,
  input wire logic       op_div,
  input wire logic       muldiv_done_q,
  input wire logic [7:0] acc_q,
  input wire logic [7:0] b_q,
  input wire logic [7:0] status_word_q,
  input wire logic       am_valid,
  input wire logic [1:0] am_mode,
  input wire logic [7:0] am_addr,
  input wire logic       iram_en_q,
  input wire logic       sfr_en_q,
  input wire logic [7:0] iram_addr_q,
  input wire logic       xm_valid,
  input wire logic       xm_via_ptr,
  input wire logic [7:0] xm_reg_value,
  input wire logic       xram_en_q,
  input wire logic [15:0] xram_addr_q,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_hit_q,
  input wire logic [7:0] sfr_rdata_q
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_done_follows_op: assert property (muldiv_done_q == $past(op_mul | op_div))
    else $error("done pulse wrong");
  a_parity_live: assert property (status_word_q[cdp_pkg::SW_PAR] == ^acc_q)
    else $error("parity wrong");
  a_bank_map: assert property (am_valid && am_mode == cdp_pkg::AM_REGISTER |=> iram_en_q &&
    iram_addr_q == {3'h0, $past(status_word_q[4:3]), $past(am_addr[2:0])}) else $error("bank address wrong");
  a_lower_both: assert property (am_valid && !am_addr[7] && (am_mode == cdp_pkg::AM_DIRECT ||
    am_mode == cdp_pkg::AM_INDIRECT) |=> iram_en_q && iram_addr_q == $past(am_addr)) else $error("lower ram");
  a_upper_indirect: assert property (am_valid && am_mode == cdp_pkg::AM_INDIRECT |=> iram_en_q && !sfr_en_q)
    else $error("indirect not ram");
  a_sfr_direct: assert property (am_valid && am_mode == cdp_pkg::AM_DIRECT && am_addr[7] |=> sfr_en_q && !iram_en_q)
    else $error("direct high not register");
  a_page_low: assert property (xm_valid && !xm_via_ptr |=> xram_en_q && xram_addr_q[7:0] == $past(xm_reg_value))
    else $error("page move low byte");
  a_user_kept: assert property (!(sfr_wr && sfr_addr == cdp_pkg::ADDR_STATUS_WORD) |=>
    $stable({status_word_q[5], status_word_q[1]})) else $error("user flag altered");
  a_div_zero: assert property (op_div && !op_mul && b_q == 8'h00 |=> status_word_q[cdp_pkg::SW_OVF] &&
    acc_q == $past(acc_q)) else $error("zero divisor");
  a_unmapped_read: assert property (sfr_rd && sfr_addr == 8'h87 |=> !sfr_hit_q && sfr_rdata_q == 8'h00)
    else $error("unmapped read");

  c_mul: cover property (op_mul ##1 muldiv_done_q);
  c_ptr_move: cover property (xm_valid && xm_via_ptr);
  c_upper: cover property (am_valid && am_mode == cdp_pkg::AM_INDIRECT && am_addr[7]);
endmodule : cdp_datapath_monitor

bind cdp_datapath cdp_datapath_monitor cdp_datapath_monitor_inst (.*);

// ===== sim/cdp_mem_model.sv
// Far-side data memory model: counts internal and external RAM accesses.
// Assumes one-cycle enable pulses from the datapath.
`timescale 1ns/1ps
module cdp_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        iram_en_q,
  input  wire logic        xram_en_q,
  input  wire logic [15:0] xram_addr_q,
  output logic      [7:0]  n_iram_q,
  output logic      [7:0]  n_xram_q,
  output logic             x_bad_q
);
  always_ff @(posedge ref_clk)
    n_iram_q <= rst ? 8'h00 : n_iram_q + 8'(iram_en_q);
  always_ff @(posedge ref_clk)
    n_xram_q <= rst ? 8'h00 : n_xram_q + 8'(xram_en_q);
  // External RAM holds 512 bytes only
  always_ff @(posedge ref_clk)
    x_bad_q <= !rst && (x_bad_q || (xram_en_q && xram_addr_q > 16'h01ff));
endmodule : cdp_mem_model

// ===== sim/cdp_datapath_tb_top.sv
// Testbench for cdp_datapath: register, arithmetic, pointer and address tests.
// Assumes the monitor is bound by its own file.
`timescale 1ns/1ps
module cdp_datapath_tb_top;
  logic        ref_clk, rst, sfr_wr, sfr_rd, acc_we, flag_we, carry_in, half_in, ovf_in;
  logic        op_mul, op_div, ptr_load, ptr_inc, am_valid, xm_valid, xm_via_ptr;
  logic        sfr_hit_q, muldiv_done_q, iram_en_q, sfr_en_q, am_fault_q, xram_en_q, x_bad;
  logic [1:0]  am_mode;
  logic [7:0]  sfr_addr, sfr_wdata, acc_wdata, am_addr, xm_reg_value, n_iram, n_xram;
  logic [7:0]  sfr_rdata_q, iram_addr_q, acc_q, b_q, status_word_q;
  logic [15:0] ptr_wdata, data_pointer_q, xram_addr_q;
  int          errors, checks, cyc;

  cdp_datapath cdp_datapath_inst (.*);
  cdp_mem_model cdp_mem_model_inst (.ref_clk(ref_clk), .rst(rst), .iram_en_q(iram_en_q),
    .xram_en_q(xram_en_q), .xram_addr_q(xram_addr_q), .n_iram_q(n_iram), .n_xram_q(n_xram), .x_bad_q(x_bad));

  always #4 ref_clk = ~ref_clk;

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // Idle edge first so a strobe lowered by the last call is seen low
    tick();
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    tick();
    sfr_wr = 1'h0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tick();
    sfr_addr = a;
    sfr_rd = 1'h1;
    tick();
    sfr_rd = 1'h0;
    chk(sfr_rdata_q, e);
  endtask : rdc

  task automatic arith(input logic m, input logic [7:0] a, b, ea, eb);
    acc_wdata = a;
    acc_we = 1'h1;
    wr(cdp_pkg::ADDR_B, b);
    acc_we = 1'h0;
    op_mul = m;
    op_div = !m;
    tick();
    op_mul = 1'h0;
    op_div = 1'h0;
    chk(muldiv_done_q, 1'h1);
    chk(acc_q, ea);
    chk(b_q, eb);
  endtask : arith

  task automatic am(input logic [1:0] m, input logic [7:0] a, input logic [1:0] en, input logic [7:0] ea);
    tick();
    am_mode = m;
    am_addr = a;
    am_valid = 1'h1;
    tick();
    am_valid = 1'h0;
    chk({iram_en_q, sfr_en_q}, en);
    if (en[1])
      chk(iram_addr_q, ea);
  endtask : am

  task automatic xm(input logic p, input logic [7:0] r, input logic [15:0] e);
    tick();
    xm_via_ptr = p;
    xm_reg_value = r;
    xm_valid = 1'h1;
    tick();
    xm_valid = 1'h0;
    chk(xram_en_q, 1'h1);
    chk(xram_addr_q, e);
  endtask : xm

  initial
  begin
    ref_clk = 1'h0;
    rst = 1'h1;
    {sfr_wr, sfr_rd, acc_we, flag_we, carry_in, half_in, ovf_in, op_mul, op_div} = '0;
    {ptr_load, ptr_inc, am_valid, xm_valid, xm_via_ptr, am_mode, ptr_wdata} = '0;
    {sfr_addr, sfr_wdata, acc_wdata, am_addr, xm_reg_value} = '0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    rdc(cdp_pkg::ADDR_ARITH_MODE, 8'h00);
    rdc(cdp_pkg::ADDR_XRAM_PAGE, 8'h00);
    wr(cdp_pkg::ADDR_XRAM_PAGE, 8'ha5);
    rdc(cdp_pkg::ADDR_XRAM_PAGE, 8'ha5);
    chk(sfr_hit_q, 1'h1);
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'hff);
    rdc(cdp_pkg::ADDR_ARITH_MODE, cdp_pkg::MODE_MASK);
    rdc(8'h87, 8'h00);
    chk(sfr_hit_q, 1'h0);
    wr(cdp_pkg::ADDR_STATUS_WORD, 8'hff);
    rdc(cdp_pkg::ADDR_STATUS_WORD, 8'hfe);
    acc_wdata = 8'h07;
    acc_we = 1'h1;
    tick();
    acc_we = 1'h0;
    chk(status_word_q, 8'hff);
    {flag_we, half_in} = 2'h3;
    tick();
    {flag_we, half_in} = 2'h0;
    chk(status_word_q, 8'h7b);
    {flag_we, carry_in, half_in, ovf_in} = 4'hf;
    tick();
    {flag_we, carry_in, half_in, ovf_in} = 4'h0;
    chk(status_word_q, 8'hff);
    $display("test registers done");
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(cdp_pkg::ADDR_PTR_LOW + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 4; i++)
      rdc(cdp_pkg::ADDR_PTR_LOW + 8'(i), 8'h11 * 8'(i + 1));
    chk(data_pointer_q, 16'h2211);
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h01);
    tick();
    chk(data_pointer_q, 16'h4433);
    ptr_wdata = 16'h01ff;
    ptr_load = 1'h1;
    tick();
    ptr_load = 1'h0;
    tick();
    chk(data_pointer_q, 16'h01ff);
    rdc(cdp_pkg::ADDR_PTR2_HIGH, 8'h01);
    rdc(cdp_pkg::ADDR_PTR_LOW, 8'h11);
    xm(1'h1, 8'h00, 16'h01ff);
    ptr_inc = 1'h1;
    tick();
    ptr_inc = 1'h0;
    tick();
    chk(data_pointer_q, 16'h0200);
    wr(cdp_pkg::ADDR_XRAM_PAGE, 8'h01);
    xm(1'h0, 8'h23, 16'h0123);
    $display("test pointers done");
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h00);
    wr(cdp_pkg::ADDR_EXTENSION, 8'h5a);
    arith(1'h1, 8'hff, 8'hff, 8'h01, 8'hfe);
    chk(status_word_q[2], 1'h1);
    rdc(cdp_pkg::ADDR_EXTENSION, 8'h5a);
    arith(1'h1, 8'h02, 8'h03, 8'h06, 8'h00);
    chk(status_word_q[2], 1'h0);
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h0c);
    wr(cdp_pkg::ADDR_EXTENSION, 8'h12);
    arith(1'h1, 8'h34, 8'h56, 8'h78, 8'h1d);
    rdc(cdp_pkg::ADDR_EXTENSION, 8'h06);
    wr(cdp_pkg::ADDR_EXTENSION, 8'h12);
    arith(1'h0, 8'h34, 8'h56, 8'h36, 8'h10);
    rdc(cdp_pkg::ADDR_EXTENSION, 8'h00);
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h00);
    arith(1'h0, 8'hfb, 8'h0a, 8'h19, 8'h01);
    arith(1'h0, 8'h5c, 8'h00, 8'h5c, 8'h00);
    chk(status_word_q[2], 1'h1);
    $display("test arithmetic done");
    for (int k = 0; k < 4; k++)
    begin
      wr(cdp_pkg::ADDR_STATUS_WORD, 8'(k << 3));
      am(cdp_pkg::AM_REGISTER, 8'h05, 2'h2, 8'(8 * k + 5));
    end
    am(cdp_pkg::AM_DIRECT, 8'h40, 2'h2, 8'h40);
    am(cdp_pkg::AM_INDIRECT, 8'h40, 2'h2, 8'h40);
    am(cdp_pkg::AM_INDIRECT, 8'h90, 2'h2, 8'h90);
    am(cdp_pkg::AM_DIRECT, 8'h90, 2'h1, 8'h00);
    am(2'h2, 8'h40, 2'h0, 8'h00);
    chk(am_fault_q, 1'h1);
    chk(n_iram, 8'h07);
    chk(n_xram, 8'h02);
    chk(x_bad, 1'h0);
    $display("test addressing done");
    // Reset in mid-run must bring arithmetic back to narrow mode
    wr(cdp_pkg::ADDR_ARITH_MODE, 8'h0c);
    rst = 1'h1;
    tick();
    rst = 1'h0;
    rdc(cdp_pkg::ADDR_ARITH_MODE, 8'h00);
    $display("test reset done");
    end_of_test();
  end
endmodule : cdp_datapath_tb_top
